// ### rtl/ecr_regs.sv
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ecr_defs.svh"
module ecr_regs
	import ecr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`ECR_AW-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [`ECR_DW-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [`ECR_AW-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [`ECR_DW-1:0] rdata,
	output logic [1:0] rresp,
	input wire ecr_events_s events,
	input wire logic tx_single_collision,
	input wire ecr_factory_s factory,
	output ecr_cfg_s cfg,
	output logic irq
);
	// Reset release synchroniser.
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Bus front end.
	logic wr_fire;
	ecr_wreq_s wreq;
	logic wr_ok;
	logic rd_fire;
	logic [`ECR_AW-1:0] rd_addr;
	logic rd_ok;
	logic [`ECR_DW-1:0] rd_data;

	ecr_axil_port u_port (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.wr_fire(wr_fire),
		.wreq(wreq),
		.wr_ok(wr_ok),
		.rd_fire(rd_fire),
		.rd_addr(rd_addr),
		.rd_ok(rd_ok),
		.rd_data(rd_data)
	);

	// Applies a base, clear, set or invert access to one register word.
	function automatic logic [31:0] ecr_apply(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0] strb,
		input ecr_op_e op,
		input logic [31:0] mask
	);
		logic [31:0] lanes;
		logic [31:0] bits;
		logic [31:0] res;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		bits = data & lanes;
		case (op)
			ECR_OP_WRITE: res = (old & ~lanes) | bits;
			ECR_OP_CLR: res = old & ~bits;
			ECR_OP_SET: res = old | bits;
			ECR_OP_INV: res = old ^ bits;
			default: res = old;
		endcase
		return res & mask;
	endfunction : ecr_apply

	// Plain read/write registers, in table order.
	localparam logic [15:0] PLAIN_OFF [`ECR_NPLAIN] = '{
		`ECR_OFF_PMM0,
		`ECR_OFF_PMM1,
		`ECR_OFF_PMCS,
		`ECR_OFF_PMO,
		`ECR_OFF_RXFC,
		`ECR_OFF_RXWM,
		`ECR_OFF_IEN
	};
	localparam logic [31:0] PLAIN_MASK [`ECR_NPLAIN] = '{
		`ECR_MASK_FULL,
		`ECR_MASK_FULL,
		`ECR_MASK_HALF,
		`ECR_MASK_HALF,
		`ECR_MASK_HALF,
		`ECR_MASK_RXWM,
		`ECR_MASK_IRQ
	};
	localparam logic [`ECR_NPLAIN-1:0] FACTORY_SEL = `ECR_FACTORY_SEL;

	// Write decode.
	wire ecr_op_e wr_op = ecr_op_e'(wreq.addr[3:2]);
	wire [11:0] wr_base = wreq.addr[15:4];
	wire wr_irq = wr_fire && wr_base == `ECR_OFF_IRQ >> 4;
	wire wr_scol = wr_fire && wr_base == `ECR_OFF_SCOL >> 4;

	// Read decode. Alias addresses read as zero and have no side effect.
	wire ecr_op_e rd_op = ecr_op_e'(rd_addr[3:2]);
	wire [11:0] rd_base = rd_addr[15:4];
	wire rd_is_base = rd_op == ECR_OP_WRITE;
	wire rd_irq_hit = rd_base == `ECR_OFF_IRQ >> 4;
	wire rd_scol_hit = rd_base == `ECR_OFF_SCOL >> 4;
	// A read aimed at the upper half only leaves both low byte lanes unused.
	wire rd_low_lanes = ~rd_addr[1];
	wire rd_clr_irq = rd_fire && rd_irq_hit && rd_is_base;
	wire rd_clr_scol = rd_fire && rd_scol_hit && rd_is_base && rd_low_lanes;

	// Factory values are taken on the first edge after reset release.
	logic load_factory;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			load_factory <= 1'b1;
		end else begin
			load_factory <= 1'b0;
		end
	end

	wire [31:0] factory_val [`ECR_NPLAIN];
	assign factory_val[0] = `ECR_RST_ZERO;
	assign factory_val[1] = `ECR_RST_ZERO;
	assign factory_val[2] = `ECR_RST_ZERO;
	assign factory_val[3] = `ECR_RST_ZERO;
	assign factory_val[4] = factory.receive_filter_config;
	assign factory_val[5] = factory.receive_watermarks;
	assign factory_val[6] = `ECR_RST_ZERO;

	logic [31:0] plain_q [`ECR_NPLAIN];
	wire [`ECR_NPLAIN-1:0] wr_plain;
	wire [`ECR_NPLAIN-1:0] rd_plain;
	wire [31:0] rd_acc [`ECR_NPLAIN+1];

	assign rd_acc[0] = `ECR_RST_ZERO;

	genvar gi;
	generate
		for (gi = 0; gi < `ECR_NPLAIN; gi++) begin : g_plain
			wire [31:0] next_val;
			assign wr_plain[gi] = wr_fire && wr_base == PLAIN_OFF[gi][15:4];
			assign rd_plain[gi] = rd_base == PLAIN_OFF[gi][15:4];
			assign next_val = ecr_apply(plain_q[gi], wreq.data, wreq.strb, wr_op, PLAIN_MASK[gi]);
			assign rd_acc[gi+1] = rd_acc[gi] | ((rd_plain[gi] && rd_is_base) ? plain_q[gi] : `ECR_RST_ZERO);

			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					plain_q[gi] <= `ECR_RST_ZERO;
				end else if (load_factory && FACTORY_SEL[gi]) begin
					plain_q[gi] <= factory_val[gi] & PLAIN_MASK[gi];
				end else if (wr_plain[gi]) begin
					plain_q[gi] <= next_val;
				end
			end
		end
	endgenerate

	// Interrupt flags: sticky, set by events, cleared by a base read or aliases.
	logic [31:0] irq_flags;
	wire [31:0] event_bits = {16'h0000, events} & `ECR_MASK_IRQ;
	wire [31:0] flags_sw = ecr_apply(irq_flags, wreq.data, wreq.strb, wr_op, `ECR_MASK_IRQ);
	wire [31:0] flags_base = rd_clr_irq ? `ECR_RST_ZERO : (wr_irq ? flags_sw : irq_flags);
	// An event in the clearing cycle still lands.
	wire [31:0] next_irq_flags = flags_base | event_bits;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_flags <= `ECR_RST_ZERO;
		end else begin
			irq_flags <= next_irq_flags;
		end
	end

	// Single-collision frame counter, fed only by the transmit side.
	logic [15:0] single_collision_count;
	wire [31:0] count_word = {16'h0000, single_collision_count};
	wire [31:0] count_sw = ecr_apply(count_word, wreq.data, wreq.strb, wr_op, `ECR_MASK_HALF);
	wire [15:0] count_base = rd_clr_scol ? 16'h0000 : (wr_scol ? count_sw[15:0] : single_collision_count);
	// A frame finishing in the clearing cycle is counted after the clear.
	wire [15:0] next_single_collision_count = count_base + {15'h0000, tx_single_collision};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			single_collision_count <= 16'h0000;
		end else begin
			single_collision_count <= next_single_collision_count;
		end
	end

	// Read data and decode answers.
	wire [31:0] rd_irq_val = (rd_irq_hit && rd_is_base) ? irq_flags : `ECR_RST_ZERO;
	wire [31:0] rd_scol_val = (rd_scol_hit && rd_is_base) ? count_word : `ECR_RST_ZERO;
	assign rd_data = rd_acc[`ECR_NPLAIN] | rd_irq_val | rd_scol_val;
	assign rd_ok = |rd_plain || rd_irq_hit || rd_scol_hit;
	assign wr_ok = |wr_plain || wr_irq || wr_scol;

	// Level interrupt, registered.
	wire irq_pending = |(irq_flags & plain_q[6]);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_pending;
		end
	end

	// Configuration towards the datapath.
	assign cfg.pattern_mask_low = plain_q[0];
	assign cfg.pattern_mask_high = plain_q[1];
	assign cfg.pattern_checksum = plain_q[2][15:0];
	assign cfg.pattern_offset = plain_q[3][15:0];
	assign cfg.receive_filter_config = plain_q[4][15:0];
	assign cfg.full_watermark = plain_q[5][23:16];
	assign cfg.empty_watermark = plain_q[5][7:0];
endmodule : ecr_regs

// ### inc/ecr_defs.svh
`ifndef ECR_DEFS_SVH
`define ECR_DEFS_SVH

`define ECR_AW 16
`define ECR_DW 32
`define ECR_NPLAIN 7

`define ECR_OFF_PMM0 16'h9060
`define ECR_OFF_PMM1 16'h9070
`define ECR_OFF_PMCS 16'h9080
`define ECR_OFF_PMO 16'h9090
`define ECR_OFF_RXFC 16'h90A0
`define ECR_OFF_RXWM 16'h90B0
`define ECR_OFF_IEN 16'h90C0
`define ECR_OFF_IRQ 16'h90D0
`define ECR_OFF_SCOL 16'h9200

`define ECR_MASK_FULL 32'hFFFFFFFF
`define ECR_MASK_HALF 32'h0000FFFF
`define ECR_MASK_RXWM 32'h00FF00FF
`define ECR_MASK_IRQ 32'h000063EF
`define ECR_RST_ZERO 32'h00000000
`define ECR_FACTORY_SEL 7'h30

`define ECR_RESP_OKAY 2'h0
`define ECR_RESP_DECERR 2'h3

`endif

// ### inc/ecr_pkg.sv
package ecr_pkg;

	typedef enum logic [1:0] {
		ECR_OP_WRITE = 2'h0,
		ECR_OP_CLR = 2'h1,
		ECR_OP_SET = 2'h2,
		ECR_OP_INV = 2'h3
	} ecr_op_e;

	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} ecr_wreq_s;

	typedef struct packed {
		logic rsvd15;
		logic tx_bus_error_flag;
		logic rx_bus_error_flag;
		logic [2:0] rsvd12;
		logic empty_watermark_flag;
		logic full_watermark_flag;
		logic rx_done_flag;
		logic packet_pending_flag;
		logic rx_active_flag;
		logic rsvd4;
		logic tx_done_flag;
		logic tx_abort_flag;
		logic rx_buffer_unavailable_flag;
		logic rx_overflow_flag;
	} ecr_events_s;

	typedef struct packed {
		logic [31:0] receive_filter_config;
		logic [31:0] receive_watermarks;
	} ecr_factory_s;

	typedef struct packed {
		logic [31:0] pattern_mask_high;
		logic [31:0] pattern_mask_low;
		logic [15:0] pattern_checksum;
		logic [15:0] pattern_offset;
		logic [15:0] receive_filter_config;
		logic [7:0] full_watermark;
		logic [7:0] empty_watermark;
	} ecr_cfg_s;

endpackage : ecr_pkg

// ### rtl/ecr_axil_port.sv
`timescale 1ns/1ps
`include "ecr_defs.svh"
module ecr_axil_port
	import ecr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`ECR_AW-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [`ECR_DW-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [`ECR_AW-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [`ECR_DW-1:0] rdata,
	output logic [1:0] rresp,
	output logic wr_fire,
	output ecr_wreq_s wreq,
	input wire logic wr_ok,
	output logic rd_fire,
	output logic [`ECR_AW-1:0] rd_addr,
	input wire logic rd_ok,
	input wire logic [`ECR_DW-1:0] rd_data
);
	// Address and data are held until both are in, so either order works.
	assign wr_fire = ~awready & ~wready & ~bvalid;
	assign rd_fire = ~arready & ~rvalid;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			awready <= 1'b1;
			wready <= 1'b1;
			wreq <= '0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				wreq.addr <= awaddr;
			end else if (wr_fire) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				wreq.data <= wdata;
				wreq.strb <= wstrb;
			end else if (wr_fire) begin
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= `ECR_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? `ECR_RESP_OKAY : `ECR_RESP_DECERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			arready <= 1'b1;
			rd_addr <= '0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `ECR_RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rd_addr <= araddr;
			end else if (rd_fire) begin
				arready <= 1'b1;
			end
			if (rd_fire) begin
				rvalid <= 1'b1;
				rdata <= rd_data;
				rresp <= rd_ok ? `ECR_RESP_OKAY : `ECR_RESP_DECERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule : ecr_axil_port

// ### tb/ecr_regs_chk.sv
`timescale 1ns/1ps
module ecr_regs_chk (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [15:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic irq
);
	logic [15:0] ra;
	always_ff @(posedge clk_sys) begin
		if (arvalid && arready) begin
			ra <= araddr;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_reset_quiet: assert property (disable iff (1'h0) !nrst |-> !irq && !bvalid && !rvalid)
		else $error("outputs active in reset");
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:30] bvalid)
		else $error("write not answered");
	a_read_answer: assert property (arvalid && arready |-> ##[1:30] rvalid)
		else $error("read not answered");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_alias_zero: assert property (rvalid && ra[3:2] != 2'h0 |-> rdata == 32'h0)
		else $error("alias read not zero");
	a_count_upper: assert property (rvalid && ra[15:2] == 14'h2480 |-> rdata[31:16] == 16'h0)
		else $error("count upper bits set");
	a_flag_bits: assert property (rvalid && ra == 16'h90D0 |-> (rdata & ~32'h000063EF) == 32'h0)
		else $error("unused flag bit set");
	a_decerr_zero: assert property (rvalid && rresp == 2'h3 |-> rdata == 32'h0)
		else $error("error read not zero");
	c_irq: cover property ($rose(irq));
	c_decerr: cover property (rvalid && rresp == 2'h3);
	c_rstall: cover property (rvalid && !rready);
endmodule : ecr_regs_chk

bind ecr_regs ecr_regs_chk chk_u (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.awvalid(awvalid),
	.awready(awready),
	.wvalid(wvalid),
	.wready(wready),
	.bvalid(bvalid),
	.bready(bready),
	.bresp(bresp),
	.arvalid(arvalid),
	.arready(arready),
	.araddr(araddr),
	.rvalid(rvalid),
	.rready(rready),
	.rdata(rdata),
	.rresp(rresp),
	.irq(irq)
);

// ### tb/tb_ecr_regs.sv
`timescale 1ns/1ps
`include "ecr_defs.svh"
module tb_ecr_regs
	import ecr_pkg::*;
;
	logic clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, tx_single_collision;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	ecr_events_s events;
	ecr_factory_s factory;
	ecr_cfg_s cfg;
	int error_cnt, check_count, cyc;

	ecr_regs dut_u (.clk_sys, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.events, .tx_single_collision, .factory, .cfg, .irq);

	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic summarize;
		$display("errors=%0d checks=%0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] q);
		bit pa;
		bit pw;
		@(posedge clk_sys);
		awvalid <= 1'h1;
		awaddr <= a;
		wvalid <= 1'h1;
		wdata <= v;
		wstrb <= s;
		pa = 1'h1;
		pw = 1'h1;
		while (pa || pw) begin
			@(posedge clk_sys);
			if (awready && pa) begin
				pa = 1'h0;
				awvalid <= 1'h0;
			end
			if (wready && pw) begin
				pw = 1'h0;
				wvalid <= 1'h0;
			end
		end
		repeat (2) @(posedge clk_sys);
		bready <= 1'h1;
		do @(posedge clk_sys); while (!(bvalid && bready));
		q = bresp;
		bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] v, output logic [1:0] q);
		@(posedge clk_sys);
		arvalid <= 1'h1;
		araddr <= a;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rready <= 1'h1;
		do @(posedge clk_sys); while (!(rvalid && rready));
		v = rdata;
		q = rresp;
		rready <= 1'h0;
	endtask : rd

	task automatic rc(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] x;
		logic [1:0] y;
		rd(a, x, y);
		chk(x, e);
		chk({30'h0, y}, {30'h0, `ECR_RESP_OKAY});
	endtask : rc

	task automatic pulse(input int n);
		@(posedge clk_sys);
		tx_single_collision <= 1'h1;
		repeat (n) @(posedge clk_sys);
		tx_single_collision <= 1'h0;
	endtask : pulse

	task automatic ev(input logic [15:0] e);
		@(posedge clk_sys);
		events <= e;
		@(posedge clk_sys);
		events <= 16'h0;
	endtask : ev

	task automatic irq_is(input logic [31:0] e);
		repeat (3) @(posedge clk_sys);
		chk({31'h0, irq}, e);
	endtask : irq_is

	// Read that meets an event or a counted frame on the edge where its clear takes effect.
	task automatic rd_hit(input logic [15:0] a, input logic [15:0] e, input logic t, output logic [31:0] v);
		logic [1:0] q;
		fork
			rd(a, v, q);
			begin
				repeat (2) @(posedge clk_sys);
				events <= e;
				tx_single_collision <= t;
				@(posedge clk_sys);
				events <= 16'h0;
				tx_single_collision <= 1'h0;
			end
		join
	endtask : rd_hit

	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready, tx_single_collision} = 7'h0;
		{awaddr, araddr, wdata, wstrb} = 68'h0;
		events = 16'h0;
		factory = {32'hA5A51234, 32'hFFFFFFFF};
		error_cnt = 0;
		check_count = 0;
		cyc = 0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'h1;
		repeat (4) @(posedge clk_sys);
		rc(16'h90A0, 32'h00001234);
		rc(16'h90B0, 32'h00FF00FF);
		chk({16'h0, cfg.receive_filter_config}, 32'h00001234);
		chk({16'h0, cfg.full_watermark, cfg.empty_watermark}, 32'h0000FFFF);
		rc(16'h9060, 32'h00000000);
		wr(16'h9060, 32'hF0F0F0F0, 4'hF, r);
		chk({30'h0, r}, {30'h0, `ECR_RESP_OKAY});
		wr(16'h9064, 32'h30000030, 4'hF, r);
		rc(16'h9060, 32'hC0F0F0C0);
		wr(16'h9068, 32'h0000FF0F, 4'h1, r);
		rc(16'h9060, 32'hC0F0F0CF);
		wr(16'h906C, 32'hFFFF0000, 4'hF, r);
		rc(16'h9060, 32'h3F0FF0CF);
		chk(cfg.pattern_mask_low, 32'h3F0FF0CF);
		rc(16'h9064, 32'h0);
		wr(16'h90AC, 32'hFFFFFFFF, 4'hF, r);
		rc(16'h90A0, 32'h0000EDCB);
		chk({16'h0, cfg.receive_filter_config}, 32'h0000EDCB);
		wr(16'h9070, 32'h12345678, 4'hF, r);
		wr(16'h907C, 32'h0000FF00, 4'h2, r);
		rc(16'h9070, 32'h1234A978);
		chk(cfg.pattern_mask_high, 32'h1234A978);
		wr(16'h9080, 32'hFFFFFFFF, 4'hF, r);
		rc(16'h9080, 32'h0000FFFF);
		chk({16'h0, cfg.pattern_checksum}, 32'h0000FFFF);
		wr(16'h9098, 32'hFFFF00FF, 4'hF, r);
		rc(16'h9090, 32'h000000FF);
		chk({16'h0, cfg.pattern_offset}, 32'h000000FF);
		wr(16'h90B4, 32'h000F000F, 4'hF, r);
		rc(16'h90B0, 32'h00F000F0);
		chk({16'h0, cfg.full_watermark, cfg.empty_watermark}, 32'h0000F0F0);
		pulse(3);
		ev(16'h23E3);
		rc(16'h9200, 32'h3);
		rc(16'h9200, 32'h0);
		pulse(2);
		rc(16'h9202, 32'h2);
		rc(16'h9200, 32'h2);
		rc(16'h9200, 32'h0);
		wr(16'h9200, 32'hABCD1234, 4'hF, r);
		rc(16'h9202, 32'h00001234);
		wr(16'h9208, 32'hFFFFFFFF, 4'hF, r);
		pulse(1);
		rc(16'h9200, 32'h0);
		rd_hit(16'h9200, 16'h0, 1'h1, d);
		chk(d, 32'h0);
		rc(16'h9200, 32'h1);
		rc(16'h90D0, 32'h000023E3);
		wr(16'h90C0, 32'h00000008, 4'hF, r);
		ev(16'h0004);
		irq_is(32'h0);
		ev(16'h0008);
		irq_is(32'h1);
		rc(16'h90D0, 32'h0000000C);
		irq_is(32'h0);
		ev(16'hFFFF);
		rc(16'h90D0, 32'h000063EF);
		rd_hit(16'h90D0, 16'h0008, 1'h0, d);
		chk(d, 32'h0);
		rc(16'h90D0, 32'h00000008);
		rd(16'h9300, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, `ECR_RESP_DECERR});
		wr(16'h9300, 32'h1, 4'hF, r);
		chk({30'h0, r}, {30'h0, `ECR_RESP_DECERR});
		summarize();
	end
endmodule : tb_ecr_regs
